// ### shared/aofs_pkg.sv
package aofs_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int SAMPLE_W = 14;
	localparam int CORE_W = 16;
	localparam int HALF_W = 7;
	// Register indexes; byte address is four times the index
	localparam logic [ADDR_W-1:0] CFG_IDX = 12'h073;
	localparam logic [ADDR_W-1:0] POWER_IDX = 12'h074;
	localparam logic [ADDR_W-1:0] RATIO_IDX = 12'h075;
	localparam logic [ADDR_W-1:0] STATUS_IDX = 12'h076;
	localparam logic [ADDR_W-1:0] CFG_ADDR = {CFG_IDX[9:0], 2'b00};
	localparam logic [ADDR_W-1:0] POWER_ADDR = {POWER_IDX[9:0], 2'b00};
	localparam logic [ADDR_W-1:0] RATIO_ADDR = {RATIO_IDX[9:0], 2'b00};
	localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX[9:0], 2'b00};
	// Output configuration fields
	localparam int CFG_CMOS_BIT = 0;
	localparam int CFG_DDR_BIT = 1;
	localparam int CFG_LOWI_BIT = 2;
	localparam int CFG_FMT_LSB = 4;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CFG_MASK = 8'h37;
	localparam logic [1:0] FMT_TWOS = 2'h0;
	localparam logic [1:0] FMT_GRAY = 2'h1;
	localparam logic [1:0] FMT_OBIN = 2'h2;
	// Three-level pin encodings
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_FLOAT = 2'h1;
	localparam logic [1:0] LVL_SUPPLY = 2'h2;
	// Power and ratio override codes; zero follows the pin
	localparam logic [1:0] PWR_PIN = 2'h0;
	localparam logic [1:0] PWR_NORMAL = 2'h1;
	localparam logic [1:0] PWR_NAP = 2'h2;
	localparam logic [1:0] PWR_SLEEP = 2'h3;
	localparam logic [1:0] RAT_PIN = 2'h0;
	localparam logic [1:0] RAT_1 = 2'h1;
	localparam logic [1:0] RAT_2 = 2'h2;
	localparam logic [1:0] RAT_4 = 2'h3;
	localparam logic [1:0] OVR_RST = 2'h0;
	// Status fields
	localparam int ST_PWR_LSB = 0;
	localparam int ST_RAT_LSB = 2;
	localparam int ST_SYNC_BIT = 4;
	localparam int ST_RELOCK_BIT = 5;
	localparam int ST_OR_BIT = 6;
	// Full-scale limits of the core value
	localparam logic signed [CORE_W-1:0] POS_FS = 16'h1FFF;
	localparam logic signed [CORE_W-1:0] NEG_FS = 16'hE000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing
	localparam int CLK_MHZ = 40;
	localparam int RELOCK_US = 100;
	localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;
	localparam int RELOCK_W = 12;
	localparam int SYNC_MAX_CYC = 30;
	localparam int SYNC_PULSE_MIN = 3;
	localparam int SYNC_GAP_MIN = 30;
	localparam int CLK_HOLD_MAX = 150;
	typedef enum logic [1:0] {
		PS_NORMAL = 2'b00,
		PS_NAP = 2'b01,
		PS_RELOCK = 2'b11,
		PS_SLEEP = 2'b10
	} aofs_pwr_t;
endpackage

// ### rtl/aofs_top.sv
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Operation
// - LVDS/CMOS and SDR/DDR selected in config
// - LVDS current 3mA default, 2mA option
// - Over-range flag updated every sample
// - Over-range codes saturate, never wrap
// - Nap or Sleep tristates all outputs
// - Power pin picks normal, sleep, nap
// - Written power mode overrides the pin
// - Allow 100us relock after halted nap
// - Twos complement, Gray, offset binary formats
// - Offset binary spans zeros to ones
// - Twos complement inverts offset binary MSB
// - Gray is offset binary XOR shifted
// - Mid-scale codes follow the formats
// - Output clock is input over ratio
// - Sync rise forces divider phase
// - Sync sampled on clock, legs complementary
// - Synchronised within thirty input cycles
// - Output clock undefined if clock interrupted
// - Clock hold lengthens recovery by hold; code ignores hold length, only a hold in nap adds the fixed 100us relock
// - Ratio pin or written ratio override
module aofs_top
	import aofs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic signed [CORE_W-1:0] core_sample_i,
	input wire logic [1:0] power_saving_select_pin_i,
	input wire logic [1:0] divider_ratio_pin_i,
	input wire logic divider_phase_sync_pos_i,
	input wire logic divider_phase_sync_neg_i,
	input wire logic serial_select_low_i,
	input wire logic input_clock_halted_i,
	output logic [SAMPLE_W-1:0] data_o,
	output logic data_oe_o,
	output logic sample_clock_out_pos_o,
	output logic sample_clock_out_neg_o,
	output logic clock_out_oe_o,
	output logic over_range_o,
	output logic over_range_oe_o,
	output logic lvds_mode_o,
	output logic ddr_mode_o,
	output logic lvds_low_current_o
);
	logic rst_m_q, rst_n_q;
	logic [7:0] cfg_q;
	logic [1:0] pwr_ovr_q, rat_ovr_q;
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [DATA_W-1:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic wr_fire, wr_hit;
	logic sync_q, sync_prev_q, sync_rise, sync_seen_q, sync_pend_q;
	logic [4:0] sync_age_q;
	logic [1:0] cnt_q, div_max, rat_code, fmt;
	logic div_clk_q, take, half_q, halt_seen_q;
	logic signed [CORE_W-1:0] core_q;
	logic [SAMPLE_W-1:0] sat, obin, obin_q, word_q, data_q;
	logic over_q, over_now;
	logic [RELOCK_W-1:0] relock_cnt_q;
	aofs_pwr_t state_q, tgt;
	localparam int SYNC_BOUND = SYNC_MAX_CYC;

	function automatic aofs_pwr_t lvl_to_pwr(input logic [1:0] lvl);
		unique case (lvl)
			LVL_GND: lvl_to_pwr = PS_NORMAL;
			LVL_SUPPLY: lvl_to_pwr = PS_NAP;
			default: lvl_to_pwr = PS_SLEEP;
		endcase
	endfunction

	function automatic logic [1:0] lvl_to_rat(input logic [1:0] lvl);
		unique case (lvl)
			LVL_GND: lvl_to_rat = RAT_2;
			LVL_SUPPLY: lvl_to_rat = RAT_4;
			default: lvl_to_rat = RAT_1;
		endcase
	endfunction

	function automatic logic [7:0] merge8(input logic [7:0] old,
		input logic [7:0] val, input logic en);
		merge8 = en ? val : old;
	endfunction

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// AXI4-Lite write path
	assign s_axi_awready_o = !aw_have_q && !bvalid_q;
	assign s_axi_wready_o = !w_have_q && !bvalid_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_hit = awaddr_q == CFG_ADDR || awaddr_q == POWER_ADDR ||
		awaddr_q == RATIO_ADDR || awaddr_q == STATUS_ADDR;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cfg_q <= CFG_RST;
			pwr_ovr_q <= OVR_RST;
			rat_ovr_q <= OVR_RST;
		end else if (wr_fire) begin
			if (awaddr_q == CFG_ADDR)
				cfg_q <= merge8(cfg_q, wdata_q[7:0], wstrb_q[0]) & CFG_MASK;
			if (awaddr_q == POWER_ADDR && wstrb_q[0])
				pwr_ovr_q <= wdata_q[1:0];
			if (awaddr_q == RATIO_ADDR && wstrb_q[0])
				rat_ovr_q <= wdata_q[1:0];
		end
	end

	// AXI4-Lite read path
	assign s_axi_arready_o = !rvalid_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			unique case (s_axi_araddr_i)
				CFG_ADDR: rdata_q[7:0] <= cfg_q;
				POWER_ADDR: rdata_q[1:0] <= pwr_ovr_q;
				RATIO_ADDR: rdata_q[1:0] <= rat_ovr_q;
				STATUS_ADDR: begin
					rdata_q[ST_PWR_LSB+:2] <= state_q;
					rdata_q[ST_RAT_LSB+:2] <= rat_code;
					rdata_q[ST_SYNC_BIT] <= sync_seen_q;
					rdata_q[ST_RELOCK_BIT] <= state_q == PS_RELOCK;
					rdata_q[ST_OR_BIT] <= over_q;
				end
				default: rresp_q <= RESP_SLVERR;
			endcase
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	assign lvds_low_current_o = cfg_q[CFG_LOWI_BIT];
	assign lvds_mode_o = !cfg_q[CFG_CMOS_BIT];
	assign ddr_mode_o = cfg_q[CFG_DDR_BIT];
	assign fmt = cfg_q[CFG_FMT_LSB+:2];

	assign rat_code = rat_ovr_q != RAT_PIN ? rat_ovr_q :
		lvl_to_rat(divider_ratio_pin_i);
	assign div_max = rat_code == RAT_4 ? 2'd3 :
		(rat_code == RAT_2 ? 2'd1 : 2'd0);

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_q <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			sync_q <= divider_phase_sync_pos_i && !divider_phase_sync_neg_i;
			sync_prev_q <= sync_q;
		end
	end

	assign sync_rise = sync_q && !sync_prev_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt_q <= 2'd0;
			div_clk_q <= 1'b1;
		end else if ((sync_rise && div_max != 2'd0) || cnt_q >= div_max) begin
			cnt_q <= 2'd0;
			div_clk_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 2'd1;
			div_clk_q <= div_max == 2'd3 ? cnt_q == 2'd0 : 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_pend_q <= 1'b0;
			sync_seen_q <= 1'b0;
			sync_age_q <= 5'd0;
		end else begin
			sync_pend_q <= sync_rise && div_max != 2'd0;
			sync_age_q <= sync_rise ? 5'd0 :
				(sync_age_q == 5'h1F ? sync_age_q : sync_age_q + 5'd1);
			if (sync_pend_q)
				sync_seen_q <= 1'b1;
			else if (wr_fire && awaddr_q == STATUS_ADDR && wstrb_q[0] &&
				wdata_q[ST_SYNC_BIT])
				sync_seen_q <= 1'b0;
		end
	end

	// output clock at input over ratio
	assign sample_clock_out_pos_o = div_max == 2'd0 ? clk_sys_i : div_clk_q;
	assign sample_clock_out_neg_o = !sample_clock_out_pos_o;
	assign take = cnt_q == 2'd0;

	assign over_now = core_sample_i > POS_FS || core_sample_i < NEG_FS;
	assign core_q = core_sample_i > POS_FS ? POS_FS :
		(core_sample_i < NEG_FS ? NEG_FS : core_sample_i);
	assign sat = core_q[SAMPLE_W-1:0];
	assign obin = {!sat[SAMPLE_W-1], sat[SAMPLE_W-2:0]};

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			obin_q <= '0;
			word_q <= '0;
			over_q <= 1'b0;
		end else if (take) begin
			over_q <= over_now;
			obin_q <= obin;
			unique case (fmt)
				FMT_GRAY: word_q <= obin ^ (obin >> 1);
				FMT_OBIN: word_q <= obin;
				default: word_q <= {!obin[SAMPLE_W-1], obin[SAMPLE_W-2:0]};
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			half_q <= 1'b0;
			data_q <= '0;
		end else begin
			half_q <= take ? 1'b0 : !half_q;
			if (!ddr_mode_o)
				data_q <= word_q;
			else if (!half_q)
				data_q <= {7'h00, word_q[SAMPLE_W-1:HALF_W]};
			else
				data_q <= {7'h00, word_q[HALF_W-1:0]};
		end
	end
	assign data_o = data_q;
	assign over_range_o = over_q;

	assign tgt = pwr_ovr_q == PWR_PIN ? lvl_to_pwr(power_saving_select_pin_i) :
		(pwr_ovr_q == PWR_NAP ? PS_NAP :
		(pwr_ovr_q == PWR_SLEEP ? PS_SLEEP : PS_NORMAL));

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= PS_SLEEP;
			halt_seen_q <= 1'b0;
			relock_cnt_q <= '0;
		end else begin
			if (state_q == PS_NAP && input_clock_halted_i)
				halt_seen_q <= 1'b1;
			else if (state_q != PS_NAP)
				halt_seen_q <= 1'b0;
			unique case (state_q)
				PS_NAP: begin
					if (tgt == PS_NORMAL && halt_seen_q) begin
						state_q <= PS_RELOCK;
						relock_cnt_q <= RELOCK_W'(RELOCK_CYC - 1);
					end else begin
						state_q <= tgt;
					end
				end
				PS_RELOCK: begin
					if (tgt != PS_NORMAL)
						state_q <= tgt;
					else if (relock_cnt_q == '0)
						state_q <= PS_NORMAL;
					else
						relock_cnt_q <= relock_cnt_q - 1'b1;
				end
				default: state_q <= tgt;
			endcase
		end
	end

	assign data_oe_o = state_q == PS_NORMAL;
	assign clock_out_oe_o = state_q == PS_NORMAL;
	assign over_range_oe_o = state_q == PS_NORMAL;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_q);

	over_flag_a: assert property (take |=> over_q == $past(over_now))
		else $error("over-range flag not from sample");
	sat_top_a: assert property (take && core_sample_i > POS_FS &&
		fmt == FMT_OBIN |=> word_q == 14'h3FFF)
		else $error("positive overload wrapped");
	twos_msb_a: assert property (fmt == FMT_TWOS && $stable(fmt) && !take
		|-> word_q == {!obin_q[13], obin_q[12:0]})
		else $error("twos complement mismatch");
	gray_form_a: assert property (fmt == FMT_GRAY && $stable(fmt) && !take
		|-> word_q == (obin_q ^ (obin_q >> 1)))
		else $error("gray code mismatch");
	hiz_out_a: assert property (state_q != PS_NORMAL |-> !data_oe_o &&
		!clock_out_oe_o && !over_range_oe_o)
		else $error("outputs driven in power saving");
	pin_sleep_a: assert property (pwr_ovr_q == PWR_PIN &&
		power_saving_select_pin_i == LVL_FLOAT [*2] |-> state_q == PS_SLEEP)
		else $error("pin float not sleep");
	ovr_wins_a: assert property (pwr_ovr_q == PWR_NAP [*2] |->
		state_q == PS_NAP)
		else $error("power override ignored");
	relock_hold_a: assert property (state_q == PS_RELOCK &&
		relock_cnt_q != '0 && tgt == PS_NORMAL |=> state_q == PS_RELOCK)
		else $error("relock ended early");
	sync_bound_a: assert property (sync_rise && div_max != 2'd0 |->
		##[1:SYNC_BOUND] (cnt_q == 2'd0 && sync_seen_q))
		else $error("sync not reached in time");
	level_once_a: assert property (sync_q && sync_prev_q |=>
		!sync_pend_q)
		else $error("held sync retriggered");
	ratio_pin_a: assert property (rat_ovr_q == RAT_PIN &&
		divider_ratio_pin_i == LVL_SUPPLY |-> div_max == 2'd3)
		else $error("ratio pin decode wrong");

	over_seen_c: cover property (take && over_now ##1 over_q);
	sync_done_c: cover property (sync_rise && div_max == 2'd3 ##1 sync_pend_q);
	relock_done_c: cover property (state_q == PS_RELOCK ##1
		state_q == PS_NORMAL);
	gray_use_c: cover property (fmt == FMT_GRAY && take);
endmodule

// ### verif/aofs_capture_model.sv
`timescale 1ns/1ps
module aofs_capture_model (
	input wire logic clk_i,
	input wire logic clk_out_i,
	input wire logic pulse_i,
	output logic sync_pos_o,
	output logic sync_neg_o,
	output logic sel_low_o,
	output int rise_cnt_o
);
	int gap;
	int len;
	initial begin
		sync_pos_o = 1'b0;
		gap = 30;
		len = 0;
		rise_cnt_o = 0;
	end
	assign sel_low_o = 1'b1;
	assign sync_neg_o = !sync_pos_o;
	always @(posedge clk_out_i) rise_cnt_o <= rise_cnt_o + 1;
	always @(posedge clk_i) begin
		if (len > 0) begin
			len <= len - 1;
			if (len == 1) begin
				sync_pos_o <= 1'b0;
				gap <= 0;
			end
		end else if (pulse_i && gap >= 30) begin
			sync_pos_o <= 1'b1;
			len <= 3;
		end else if (gap < 30) begin
			gap <= gap + 1;
		end
	end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import aofs_pkg::*;
	logic clk_sys_i, reset_n_i, awvalid, wvalid, bready, arvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic awready, wready, bvalid, arready, rvalid, pulse, halt;
	logic [1:0] bresp, rresp, pwr_pin, rat_pin, pchk;
	logic signed [CORE_W-1:0] core;
	logic [SAMPLE_W-1:0] data;
	logic doe, cp, cn, coe, orng, ooe, lvds, ddr, lowi, sp, sn, sel;
	int rise, meas, error_cnt, n_compared, cyc, seed;
	logic [33:0] exp_q[$];
	logic signed [15:0] fx[5] = '{16'sh1fff, 16'she000, 16'sh0000,
		16'sh2000, 16'shdfff};
	logic [4:0] pt[7] = '{5'h01, 5'h08, 5'h10, 5'h13, 5'h06, 5'h04, 5'h01};
	logic [1:0] rr[6] = '{RAT_1, RAT_2, RAT_4, RAT_PIN, RAT_PIN, RAT_PIN};
	logic [1:0] rp[6] = '{LVL_GND, LVL_FLOAT, LVL_GND, LVL_GND, LVL_SUPPLY,
		LVL_FLOAT};
	int rn[6] = '{40, 20, 10, 20, 10, 40};
	aofs_top i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .core_sample_i(core),
		.power_saving_select_pin_i(pwr_pin), .divider_ratio_pin_i(rat_pin),
		.divider_phase_sync_pos_i(sp), .divider_phase_sync_neg_i(sn),
		.serial_select_low_i(sel), .input_clock_halted_i(halt),
		.data_o(data), .data_oe_o(doe), .sample_clock_out_pos_o(cp),
		.sample_clock_out_neg_o(cn), .clock_out_oe_o(coe),
		.over_range_o(orng), .over_range_oe_o(ooe), .lvds_mode_o(lvds),
		.ddr_mode_o(ddr), .lvds_low_current_o(lowi));
	aofs_capture_model i_cap (.clk_i(clk_sys_i), .clk_out_i(cp),
		.pulse_i(pulse), .sync_pos_o(sp), .sync_neg_o(sn),
		.sel_low_o(sel), .rise_cnt_o(rise));
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	task check(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(negedge clk_sys_i) begin
		if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
		if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
		if (pchk == 2'h1) check({18'h0, doe, orng, data}, exp_q.pop_front());
		if (pchk == 2'h2) check({28'h0, doe, coe, ooe, lvds, ddr, lowi},
			exp_q.pop_front());
		if (pchk == 2'h3) check(34'(meas), exp_q.pop_front());
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa, pw, pb, ta, tw, tb;
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		while (pa || pw || pb) begin
			@(negedge clk_sys_i);
			ta = pa && awready;
			tw = pw && wready;
			tb = pb && bvalid;
			@(posedge clk_sys_i);
			if (ta) pa = 1'b0;
			if (tw) pw = 1'b0;
			if (tb) pb = 1'b0;
			awvalid <= pa;
			wvalid <= pw;
			bready <= pb;
		end
	endtask
	task rd(input logic [11:0] a, input logic [33:0] e);
		logic pa, pb, ta, tb;
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		pa = 1'b1;
		pb = 1'b1;
		while (pa || pb) begin
			@(negedge clk_sys_i);
			ta = pa && arready;
			tb = pb && rvalid;
			@(posedge clk_sys_i);
			if (ta) pa = 1'b0;
			if (tb) pb = 1'b0;
			arvalid <= pa;
			rready <= pb;
		end
	endtask
	task pin(input logic [1:0] k, input logic [33:0] e);
		exp_q.push_back(e);
		pchk <= k;
		@(posedge clk_sys_i);
		pchk <= 2'h0;
		@(posedge clk_sys_i);
	endtask
	function logic [13:0] enc(input logic signed [15:0] v, input logic [1:0] f);
		logic [13:0] o;
		o = v > POS_FS ? 14'h3fff : v < NEG_FS ? 14'h0000 : 14'(v - NEG_FS);
		if (f == FMT_TWOS) return o ^ 14'h2000;
		if (f == FMT_GRAY) return o ^ (o >> 1);
		return o;
	endfunction
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, pulse, halt} = 7'h00;
		{awaddr, araddr, wdata, pchk, cyc, error_cnt, n_compared} = '0;
		core = 16'sh0000;
		pwr_pin = LVL_GND;
		rat_pin = LVL_FLOAT;
		seed = 32'h0000_ccec;
		reset_n_i = 1'b0;
		repeat (8) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		rd(CFG_ADDR, {RESP_OKAY, 32'h0});
		pin(2'h2, 34'h3c);
		wr(CFG_ADDR, 32'hff, RESP_OKAY);
		rd(CFG_ADDR, {RESP_OKAY, 32'h37});
		pin(2'h2, 34'h3b);
		wr(12'h000, 32'h1, RESP_SLVERR);
		rd(12'h000, {RESP_SLVERR, 32'h0});
		$display("test registers done");
		for (int f = 0; f < 3; f++) begin
			wr(CFG_ADDR, 32'(f << CFG_FMT_LSB), RESP_OKAY);
			for (int i = 0; i < 15; i++) begin
				core <= i < 5 ? fx[i] : 16'($random(seed) % 12000);
				repeat (4) @(posedge clk_sys_i);
				pin(2'h1, {19'h1, core > POS_FS || core < NEG_FS,
					enc(core, f[1:0])});
			end
		end
		$display("test formats done");
		for (int i = 0; i < 7; i++) begin
			pwr_pin <= pt[i][4:3];
			wr(POWER_ADDR, 32'(pt[i][2:1]), RESP_OKAY);
			repeat (3) @(posedge clk_sys_i);
			pin(2'h2, {28'h0, {3{pt[i][0]}}, 3'h4});
		end
		wr(POWER_ADDR, 32'(PWR_NAP), RESP_OKAY);
		halt <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		halt <= 1'b0;
		wr(POWER_ADDR, 32'(PWR_NORMAL), RESP_OKAY);
		repeat (10) @(posedge clk_sys_i);
		pin(2'h2, 34'h04);
		repeat (RELOCK_CYC) @(posedge clk_sys_i);
		pin(2'h2, 34'h3c);
		$display("test power done");
		core <= 16'sh0000;
		for (int i = 0; i < 6; i++) begin
			rat_pin <= rp[i];
			wr(RATIO_ADDR, 32'(rr[i]), RESP_OKAY);
			repeat (8) @(negedge clk_sys_i);
			meas = rise;
			repeat (40) @(negedge clk_sys_i);
			meas = rise - meas;
			@(posedge clk_sys_i);
			pin(2'h3, 34'(rn[i]));
		end
		rat_pin <= LVL_GND;
		wr(RATIO_ADDR, 32'(RAT_2), RESP_OKAY);
		rd(STATUS_ADDR, {RESP_OKAY, 32'h08});
		pulse <= 1'b1;
		@(posedge clk_sys_i);
		pulse <= 1'b0;
		repeat (30) @(posedge clk_sys_i);
		rd(STATUS_ADDR, {RESP_OKAY, 32'h18});
		wr(STATUS_ADDR, 32'h10, RESP_OKAY);
		rd(STATUS_ADDR, {RESP_OKAY, 32'h08});
		$display("test divider done");
		print_verdict();
	end
endmodule
